// ### test_usb_endpoint_buffer_config.sv
// Self-checking testbench for the endpoint buffer configuration top
`timescale 1ns/1ps
module test_usb_endpoint_buffer_config import uebc_pkg::*;;
  logic        clk      = 1'b0;
  logic        rst_b    = 1'b0;
  logic        bus16    = 1'b0;
  uebc_epidx_t idx      = 3'h0;
  logic        bus_rst  = 1'b0;
  logic        pio      = 1'b0;
  logic        dma      = 1'b0;
  logic        byte_wr  = 1'b0;
  logic [15:0] fifo_cnt = 16'h0000;
  logic        tok      = 1'b0;
  logic        ack      = 1'b0;
  uebc_epidx_t ack_ep   = 3'h0;
  logic [15:0] ack_len  = 16'h0000;
  logic        cs, wr, rd, ready, en, dbl, odd_low, vld, zlp, tog, v, z;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, pkt_cnt, rv;
  logic [10:0] fsize;
  logic [1:0]  ppu, xtype;
  uebc_epidx_t tog_ep;
  int          miscompares = 0;
  int          n_checks    = 0;
  int          tog_n       = 0;

  always #10 clk = ~clk;

  uebc_mcu_model mcu (.i_clk(clk), .o_cs(cs), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_wdata(wdata), .i_rdata(rdata));

  uebc_top dut (.i_clk(clk), .i_rst_b(rst_b), .i_cs(cs), .i_wr(wr), .i_rd(rd),
    .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .i_bus16(bus16), .i_ep_index(idx),
    .i_usb_bus_reset(bus_rst), .i_pio_mode(pio), .i_dma_mode(dma), .i_in_byte_wr(byte_wr),
    .i_in_fifo_count(fifo_cnt), .i_in_token(tok), .i_out_ack(ack), .i_out_ack_ep(ack_ep),
    .i_out_ack_len(ack_len), .o_out_ack_ready(ready), .o_fifo_size_bytes(fsize),
    .o_packets_per_uframe(ppu), .o_packet_byte_count(pkt_cnt), .o_endpoint_enable(en),
    .o_double_buffer_enable(dbl), .o_endpoint_transfer_type(xtype),
    .o_odd_final_byte_low(odd_low), .o_validate_in(vld), .o_send_zlp(zlp),
    .o_toggle_reset(tog), .o_toggle_ep(tog_ep));

  always @(posedge clk) begin
    if (tog === 1'b1) begin
      tog_n <= tog_n + 1;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    mcu.read_reg(a, rv);
    chk(rv, exp);
  endtask

  // Index moves one edge ahead of any access
  task automatic sel(input uebc_epidx_t i);
    @(posedge clk);
    idx <= i;
  endtask

  // Pulse an engine event and gather the validate and empty-packet event outputs
  task automatic ev(input logic bw, input logic tk, input logic [15:0] fc);
    @(posedge clk);
    byte_wr  <= bw;
    tok      <= tk;
    fifo_cnt <= fc;
    v = 1'b0;
    z = 1'b0;
    repeat (3) begin
      @(posedge clk);
      byte_wr <= 1'b0;
      tok     <= 1'b0;
      #1;
      v = v | vld;
      z = z | zlp;
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #400000;
    miscompares++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk({5'h00, fsize}, 16'h0040);
    rdc(8'h1c, 16'h0000);
    sel(3'h2);
    mcu.write_reg(8'h04, 16'h0840);
    rdc(8'h04, 16'h0840);
    rdc(8'h1c, 16'h0040);
    sel(3'h5);
    rdc(8'h1c, 16'h0040);
    rdc(8'h04, 16'h0000);
    sel(3'h2);
    mcu.write_reg(8'h1c, 16'h003e);
    rdc(8'h1c, 16'h003e);
    chk(pkt_cnt, 16'h003e);
    for (int t = 1; t < 4; t++) begin
      mcu.write_reg(8'h08, 16'h001c | 16'(t));
      rdc(8'h08, 16'h001c | 16'(t));
      chk({14'h0000, xtype}, 16'(t));
      chk({15'h0000, dbl}, 16'h0001);
      chk({14'h0000, ppu}, (t == 2) ? 16'h0001 : 16'h0002);
    end
    chk(16'(tog_n), 16'h0001);
    chk({13'h0000, tog_ep}, 16'h0002);
    @(posedge clk);
    pio <= 1'b1;
    ev(1'b1, 1'b0, 16'h003e);
    chk({15'h0000, v}, 16'h0001);
    ev(1'b1, 1'b0, 16'h0030);
    chk({15'h0000, v}, 16'h0000);
    @(posedge clk);
    pio <= 1'b0;
    ev(1'b1, 1'b0, 16'h0040);
    chk({15'h0000, v}, 16'h0001);
    @(posedge clk);
    dma <= 1'b1;
    mcu.write_reg(8'h1c, 16'h0000);
    ev(1'b0, 1'b1, 16'h0000);
    chk({15'h0000, z}, 16'h0000);
    mcu.write_reg(8'h08, 16'h000b);
    ev(1'b0, 1'b1, 16'h0000);
    chk({15'h0000, z}, 16'h0001);
    mcu.write_reg(8'h08, 16'h0003);
    #1;
    chk({15'h0000, en}, 16'h0000);
    chk({15'h0000, dbl}, 16'h0000);
    mcu.write_reg(8'h08, 16'h000b);
    repeat (2) @(posedge clk);
    chk(16'(tog_n), 16'h0002);
    @(posedge clk);
    ack     <= 1'b1;
    ack_ep  <= 3'h3;
    ack_len <= 16'h0025;
    do @(posedge clk); while (ready !== 1'b1);
    ack <= 1'b0;
    sel(3'h3);
    rdc(8'h1c, 16'h0025);
    @(posedge clk);
    bus16 <= 1'b1;
    repeat (3) @(posedge clk);
    chk({15'h0000, odd_low}, 16'h0001);
    rdc(8'h20, 16'h0000);
    sel(3'h2);
    mcu.write_reg(8'h04, 16'h1840);
    #1;
    chk({14'h0000, ppu}, 16'h0000);
    @(posedge clk);
    bus_rst <= 1'b1;
    @(posedge clk);
    bus_rst <= 1'b0;
    rdc(8'h1c, 16'h0000);
    rdc(8'h08, 16'h0000);
    wrap_up();
  end
endmodule

// ### uebc_chk_sva.sv
// Concurrent checks on the endpoint buffer configuration top
`timescale 1ns/1ps
module uebc_chk
  import uebc_pkg::*;
(
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  // Register port
  input wire logic        i_cs,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] o_rdata,
  input wire logic        i_bus16,
  input wire uebc_epidx_t i_ep_index,
  // Engine side
  input wire logic        i_usb_bus_reset,
  input wire logic        i_dma_mode,
  input wire logic        i_in_byte_wr,
  input wire logic        i_in_token,
  input wire logic        o_out_ack_ready,
  input wire logic [10:0] o_fifo_size_bytes,
  input wire logic        o_odd_final_byte_low,
  input wire logic        o_validate_in,
  input wire logic        o_send_zlp,
  input wire logic        o_toggle_reset
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  logic rd_bad;
  logic en_wr;
  assign rd_bad = i_cs && i_rd && !(i_addr inside {8'h04, 8'h08, 8'h1c});
  assign en_wr  = i_cs && i_wr && (i_addr == 8'h08) && i_wdata[3];

  unmapped_read_a: assert property (
    rd_bad |-> ##1 o_rdata == 16'h0000) else $error("unmapped read not zero");
  type_reserved_a: assert property (
    i_cs && i_rd && i_addr == 8'h08 |-> ##1 o_rdata[15:5] == 11'h000)
    else $error("type reserved bits set");
  size_reserved_a: assert property (
    i_cs && i_rd && i_addr == 8'h04 |-> ##1 o_rdata[15:13] == 3'h0)
    else $error("size reserved bits set");
  ready_low_a: assert property (
    i_cs && i_wr && (i_addr == 8'h08 || i_addr == 8'h1c ||
    (i_addr == 8'h04 && i_ep_index != 3'h0)) |-> !o_out_ack_ready)
    else $error("ack ready during write");
  validate_cause_a: assert property (
    o_validate_in |-> $past(i_in_byte_wr) ##1 !o_validate_in)
    else $error("validate without byte write");
  zlp_cause_a: assert property (
    o_send_zlp |-> $past(i_in_token) && $past(i_dma_mode))
    else $error("empty packet without dma token");
  toggle_cause_a: assert property (
    o_toggle_reset |-> $past(en_wr)) else $error("toggle reset without enable write");
  ep0_size_a: assert property (
    i_ep_index == 3'h0 && $past(i_ep_index) == 3'h0 |-> o_fifo_size_bytes == 11'h040)
    else $error("control endpoint size changed");
  odd_lane_a: assert property (
    !$past(i_bus16) |-> !o_odd_final_byte_low) else $error("odd lane flag on 8-bit bus");
  bus_reset_a: assert property (
    $past(i_usb_bus_reset) |-> !o_validate_in && !o_send_zlp && !o_toggle_reset)
    else $error("event after bus reset");
endmodule

bind uebc_top uebc_chk u_chk (.*);

// ### uebc_mcu_model.sv
// Microcontroller model driving the register port
`timescale 1ns/1ps
module uebc_mcu_model (
  // Clock
  input  wire logic        i_clk,
  // Register port
  output logic             o_cs,
  output logic             o_wr,
  output logic             o_rd,
  output logic [7:0]       o_addr,
  output logic [15:0]      o_wdata,
  input  wire logic [15:0] i_rdata
);
  initial begin
    o_cs    = 1'b0;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_addr  = 8'hff;
    o_wdata = 16'h0000;
  end

  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_cs    <= 1'b1;
    o_wr    <= 1'b1;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_cs    <= 1'b0;
    o_wr    <= 1'b0;
    // Released lines flip so stale data never looks valid
    o_wdata <= ~d;
    o_addr  <= ~a;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_clk);
    o_cs   <= 1'b1;
    o_rd   <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_cs   <= 1'b0;
    o_rd   <= 1'b0;
    o_addr <= ~a;
    @(posedge i_clk);
    #1;
    d = i_rdata;
  endtask
endmodule

// ### uebc_mem.sv
// Per-endpoint settings memory with field write enables and registered read
`timescale 1ns/1ps
module uebc_mem
  import uebc_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // Access port
  uebc_mem_if.mem   mif
);
  uebc_entry_s mem_q [`UEBC_NUM_EP];
  uebc_entry_s merged;

  // Write-first merge so a read in the write cycle sees new fields
  always_comb begin
    merged = mem_q[mif.waddr];
    if (mif.we_count) begin
      merged.packet_byte_count = mif.wdata.packet_byte_count;
    end
    if (mif.we_size) begin
      merged.transactions_per_microframe = mif.wdata.transactions_per_microframe;
      merged.fifo_size_bytes             = mif.wdata.fifo_size_bytes;
    end
    if (mif.we_type) begin
      merged.suppress_zero_length_packet = mif.wdata.suppress_zero_length_packet;
      merged.endpoint_enable             = mif.wdata.endpoint_enable;
      merged.double_buffer_enable        = mif.wdata.double_buffer_enable;
      merged.endpoint_transfer_type      = mif.wdata.endpoint_transfer_type;
    end
  end

  // Storage itself needs no reset; validity is tracked outside
  always_ff @(posedge i_clk) begin
    if (mif.we_count || mif.we_size || mif.we_type) begin
      mem_q[mif.waddr] <= merged;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mif.rdata <= '0;
    end else if ((mif.we_count || mif.we_size || mif.we_type) && mif.waddr == mif.raddr) begin
      mif.rdata <= merged;
    end else begin
      mif.rdata <= mem_q[mif.raddr];
    end
  end
endmodule

// ### uebc_mem_if.sv
// Interface between the configuration logic and its endpoint memory
`timescale 1ns/1ps
interface uebc_mem_if;
  import uebc_pkg::*;
  logic        we_count;
  logic        we_size;
  logic        we_type;
  uebc_epidx_t waddr;
  uebc_entry_s wdata;
  uebc_epidx_t raddr;
  uebc_entry_s rdata;

  modport ctrl (output we_count, we_size, we_type, waddr, wdata, raddr, input rdata);
  modport mem  (input we_count, we_size, we_type, waddr, wdata, raddr, output rdata);
endinterface

// ### uebc_pkg.sv
// Types shared by the endpoint buffer configuration modules
package uebc_pkg;
  `include "uebc_regs.svh"

  typedef logic [`UEBC_NUM_EP-1:0]   uebc_epvec_t;
  typedef logic [`UEBC_EP_IDX_W-1:0] uebc_epidx_t;

  // One endpoint's stored settings
  typedef struct packed {
    logic [15:0] packet_byte_count;
    logic [1:0]  transactions_per_microframe;
    logic [10:0] fifo_size_bytes;
    logic        suppress_zero_length_packet;
    logic        endpoint_enable;
    logic        double_buffer_enable;
    logic [1:0]  endpoint_transfer_type;
  } uebc_entry_s;
endpackage

// ### uebc_regs.svh
// Register offsets, field positions and reset values of the endpoint buffer configuration
`ifndef UEBC_REGS_SVH
`define UEBC_REGS_SVH

`define UEBC_OFS_FIFO_SIZE   8'h04
`define UEBC_OFS_TYPE_CFG    8'h08
`define UEBC_OFS_PKT_LEN     8'h1c

`define UEBC_NUM_EP          8
`define UEBC_EP_IDX_W        3

`define UEBC_TRANS_HI        12
`define UEBC_TRANS_LO        11
`define UEBC_SIZE_HI         10
`define UEBC_ZLP_SUP_BIT     4
`define UEBC_EN_BIT          3
`define UEBC_DBL_BIT         2
`define UEBC_XTYPE_HI        1

`define UEBC_XTYPE_ISO       2'h1
`define UEBC_XTYPE_BULK      2'h2
`define UEBC_XTYPE_INT       2'h3
`define UEBC_TRANS_RSVD      2'h3

`define UEBC_PKT_LEN_RST     16'h0000
`define UEBC_EP0_FIFO_SIZE   11'h040

`endif

// ### uebc_top.sv
// Endpoint buffer sizing, type and packet length registers of the peripheral controller
`timescale 1ns/1ps

//
// Contract
// - Hold 16-bit packet byte count per indexed endpoint
// - Size write reloads every endpoint's byte count
// - Software may write smaller byte count
// - Bus reset and power-on clear byte count
// - PIO IN write reaching count validates short
// - Full packets validate without byte count
// - OUT acknowledge loads received byte count
// - Odd final byte on lower lane
// - Size setting excludes default control endpoint
// - Transactions field gives packets per microframe
// - Eleven-bit FIFO size used both speeds
// - Type register fields, cleared on resets
// - Empty packet sent unless suppressed
// - FIFO count reaching size validates buffer
// - Transfer type codes iso, bulk, interrupt
// - DMA zero length appends empty packet
// - Enable activates FIFO; re-enable resets toggle
module uebc_top
  import uebc_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // Register port
  input  wire logic        i_cs,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [7:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  output logic      [15:0] o_rdata,
  input  wire logic        i_bus16,
  input  wire uebc_epidx_t i_ep_index,
  // Protocol engine side
  input  wire logic        i_usb_bus_reset,
  input  wire logic        i_pio_mode,
  input  wire logic        i_dma_mode,
  input  wire logic        i_in_byte_wr,
  input  wire logic [15:0] i_in_fifo_count,
  input  wire logic        i_in_token,
  input  wire logic        i_out_ack,
  input  wire uebc_epidx_t i_out_ack_ep,
  input  wire logic [15:0] i_out_ack_len,
  output logic             o_out_ack_ready,
  // Indexed endpoint settings
  output logic [10:0]      o_fifo_size_bytes,
  output logic [1:0]       o_packets_per_uframe,
  output logic [15:0]      o_packet_byte_count,
  output logic             o_endpoint_enable,
  output logic             o_double_buffer_enable,
  output logic [1:0]       o_endpoint_transfer_type,
  output logic             o_odd_final_byte_low,
  // Events
  output logic             o_validate_in,
  output logic             o_send_zlp,
  output logic             o_toggle_reset,
  output uebc_epidx_t      o_toggle_ep
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [10:0] last_size;
    uebc_epvec_t reload;
    uebc_epvec_t zero;
    uebc_epvec_t size_vld;
    uebc_epvec_t type_vld;
    logic [15:0] rdata;
    logic        validate;
    logic        zlp;
    logic        toggle;
    uebc_epidx_t toggle_ep;
    logic        odd_low;
  } uebc_state_s;

  uebc_state_s st_r;
  uebc_state_s st_nxt;
  uebc_mem_if  mif ();

  uebc_mem u_mem (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .mif     (mif)
  );

  // packets per microframe, reserved code gives none for iso and interrupt, non-periodic types always give one
  function automatic logic [1:0] uebc_pkts(input logic [1:0] ntr, input logic [1:0] xt);
    if (xt != `UEBC_XTYPE_ISO && xt != `UEBC_XTYPE_INT) begin
      return 2'h1;
    end
    if (ntr == `UEBC_TRANS_RSVD) begin
      return 2'h0;
    end
    return ntr + 2'h1;
  endfunction

  // ----------------------------------------------------------------
  // Effective settings of the indexed endpoint
  // ----------------------------------------------------------------
  uebc_entry_s cur;
  logic [10:0] eff_size;
  logic [1:0]  eff_trans;
  logic [15:0] eff_count;
  logic [4:0]  eff_type;
  logic        wr_any;
  logic        wr_size;
  logic        wr_type;
  logic        wr_count;
  logic        ep0_sel;

  assign cur     = mif.rdata;
  assign ep0_sel = (i_ep_index == '0);

  always_comb begin
    // default control endpoint keeps fixed sizing
    if (ep0_sel) begin
      eff_size  = `UEBC_EP0_FIFO_SIZE;
      eff_trans = 2'h0;
    end else if (st_r.size_vld[i_ep_index]) begin
      eff_size  = cur.fifo_size_bytes;
      eff_trans = cur.transactions_per_microframe;
    end else begin
      eff_size  = 11'h000;
      eff_trans = 2'h0;
    end
    // type fields read as zero until written
    if (st_r.type_vld[i_ep_index]) begin
      eff_type = {cur.suppress_zero_length_packet, cur.endpoint_enable,
                  cur.double_buffer_enable, cur.endpoint_transfer_type};
    end else begin
      eff_type = 5'h00;
    end
    // pending reload shows last written size
    if (st_r.zero[i_ep_index]) begin
      eff_count = `UEBC_PKT_LEN_RST;
    end else if (st_r.reload[i_ep_index]) begin
      eff_count = {5'h00, st_r.last_size};
    end else begin
      eff_count = cur.packet_byte_count;
    end
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  // every access hits the indexed endpoint
  assign wr_any   = i_cs && i_wr;
  assign wr_size  = wr_any && (i_addr == `UEBC_OFS_FIFO_SIZE) && !ep0_sel;
  assign wr_type  = wr_any && (i_addr == `UEBC_OFS_TYPE_CFG);
  assign wr_count = wr_any && (i_addr == `UEBC_OFS_PKT_LEN);

  // OUT length loads share the write port; bus writes win
  assign o_out_ack_ready = !(wr_size || wr_type || wr_count);

  always_comb begin
    mif.raddr    = i_ep_index;
    mif.waddr    = i_ep_index;
    mif.we_size  = wr_size;
    mif.we_type  = wr_type;
    mif.we_count = wr_count;
    mif.wdata    = '0;
    mif.wdata.transactions_per_microframe = i_wdata[`UEBC_TRANS_HI:`UEBC_TRANS_LO];
    mif.wdata.fifo_size_bytes             = i_wdata[`UEBC_SIZE_HI:0];
    mif.wdata.suppress_zero_length_packet = i_wdata[`UEBC_ZLP_SUP_BIT];
    mif.wdata.endpoint_enable             = i_wdata[`UEBC_EN_BIT];
    mif.wdata.double_buffer_enable        = i_wdata[`UEBC_DBL_BIT];
    mif.wdata.endpoint_transfer_type      = i_wdata[`UEBC_XTYPE_HI:0];
    // software byte count, smaller value allowed
    mif.wdata.packet_byte_count           = i_wdata;
    if (i_out_ack && o_out_ack_ready) begin
      mif.waddr    = i_out_ack_ep;
      mif.we_count = 1'b1;
      mif.wdata.packet_byte_count = i_out_ack_len;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt          = st_r;
    st_nxt.validate = 1'b0;
    st_nxt.zlp      = 1'b0;
    st_nxt.toggle   = 1'b0;
    if (i_cs && i_rd) begin
      case (i_addr)
        `UEBC_OFS_FIFO_SIZE: st_nxt.rdata = {3'h0, eff_trans, eff_size};
        `UEBC_OFS_TYPE_CFG:  st_nxt.rdata = {11'h000, eff_type};
        `UEBC_OFS_PKT_LEN:   st_nxt.rdata = eff_count;
        default:             st_nxt.rdata = 16'h0000;
      endcase
    end
    // size write reloads all byte counts
    if (wr_size) begin
      st_nxt.last_size            = i_wdata[`UEBC_SIZE_HI:0];
      st_nxt.reload               = '1;
      st_nxt.zero                 = '0;
      st_nxt.size_vld[i_ep_index] = 1'b1;
    end
    if (wr_count) begin
      st_nxt.reload[i_ep_index] = 1'b0;
      st_nxt.zero[i_ep_index]   = 1'b0;
    end
    if (i_out_ack && o_out_ack_ready) begin
      st_nxt.reload[i_out_ack_ep] = 1'b0;
      st_nxt.zero[i_out_ack_ep]   = 1'b0;
    end
    if (wr_type) begin
      st_nxt.type_vld[i_ep_index] = 1'b1;
      // disable then enable resets data toggle
      if (i_wdata[`UEBC_EN_BIT] && !eff_type[`UEBC_EN_BIT]) begin
        st_nxt.toggle    = 1'b1;
        st_nxt.toggle_ep = i_ep_index;
      end
    end
    // PIO short packet validated at byte count
    if (i_in_byte_wr && i_pio_mode && eff_type[`UEBC_EN_BIT] &&
        eff_count != 16'h0000 && i_in_fifo_count == eff_count) begin
      st_nxt.validate = 1'b1;
    end
    // full packet validated, no byte count needed
    if (i_in_byte_wr && eff_type[`UEBC_EN_BIT] && eff_size != 11'h000 &&
        i_in_fifo_count == {5'h00, eff_size}) begin
      st_nxt.validate = 1'b1;
    end
    if (i_in_token && i_dma_mode && eff_type[`UEBC_EN_BIT] &&
        !eff_type[`UEBC_ZLP_SUP_BIT] && (eff_count == 16'h0000 || eff_size == 11'h000)) begin
      st_nxt.zlp = 1'b1;
    end
    // odd length ends on lower byte lane
    st_nxt.odd_low = i_bus16 && eff_count[0];
    // bus reset clears counts and settings
    if (i_usb_bus_reset) begin
      st_nxt.reload   = '0;
      st_nxt.zero     = '1;
      st_nxt.size_vld = '0;
      st_nxt.type_vld = '0;
      st_nxt.validate = 1'b0;
      st_nxt.zlp      = 1'b0;
      st_nxt.toggle   = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r      <= '0;
      st_r.zero <= '1;
    end else begin
      st_r      <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // indexed byte count presented to FIFO
  assign o_packet_byte_count      = eff_count;
  assign o_fifo_size_bytes        = eff_size;
  assign o_packets_per_uframe     = uebc_pkts(eff_trans, eff_type[`UEBC_XTYPE_HI:0]);
  assign o_endpoint_enable        = eff_type[`UEBC_EN_BIT];
  assign o_double_buffer_enable   = eff_type[`UEBC_DBL_BIT];
  assign o_endpoint_transfer_type = eff_type[`UEBC_XTYPE_HI:0];
  assign o_odd_final_byte_low     = st_r.odd_low;
  assign o_rdata                  = st_r.rdata;
  assign o_validate_in            = st_r.validate;
  // empty packet unless suppress flag set
  assign o_send_zlp               = st_r.zlp;
  assign o_toggle_reset           = st_r.toggle;
  assign o_toggle_ep              = st_r.toggle_ep;
endmodule
